// >>> logic/mcl_params.svh
`ifndef MCL_PARAMS_SVH
`define MCL_PARAMS_SVH

// Geometry of the line state array
`define MCL_LINES 8
`define MCL_IDX_W 3

// Geometry of the translation store
`define MCL_PAGES 8
`define MCL_PAGE_W 3
`define MCL_FRAME_W 8

// Reset values
`define MCL_FRAME_RST 8'h00

`endif

// >>> logic/mcl_pkg.sv
`include "mcl_params.svh"

package mcl_pkg;

	// Coherency state of one cache line
	typedef enum logic [2:0] {
		line_inv = 3'h0,
		line_shr = 3'h1,
		line_exc = 3'h2,
		line_own = 3'h3,
		line_mod = 3'h4
	} mcl_line_t;

	// Local miss and upgrade sequencer, Gray along the write miss path
	typedef enum logic [1:0] {
		fsm_idle = 2'h0,
		fsm_probe = 2'h1,
		fsm_fill = 2'h3,
		fsm_upgrade = 2'h2
	} mcl_fsm_t;

	typedef logic [`MCL_IDX_W-1:0] mcl_idx_t;
	typedef logic [`MCL_PAGE_W-1:0] mcl_page_t;
	typedef logic [`MCL_FRAME_W-1:0] mcl_frame_t;

endpackage

// >>> logic/mcl_line_state.sv
`include "mcl_params.svh"

module mcl_line_state
	import mcl_pkg::*;
(
	// Clock, reset, enable
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	// Local requests
	input wire logic lcl_req,
	input wire logic lcl_write,
	input wire mcl_idx_t lcl_idx,
	output logic lcl_ready,
	output logic lcl_done,
	output mcl_line_t lcl_state,
	// Outgoing probes and memory read
	output logic prb_req,
	output logic prb_write,
	output mcl_idx_t prb_idx,
	input wire logic prb_ack,
	input wire logic prb_shared,
	input wire logic prb_cache_data,
	output logic mem_rd,
	// Incoming probes
	input wire logic snp_valid,
	input wire logic snp_write,
	input wire logic snp_caching,
	input wire mcl_idx_t snp_idx,
	output logic snp_hit,
	output logic snp_supply,
	// Translation store
	input wire logic xlat_fill,
	input wire mcl_page_t xlat_fill_page,
	input wire mcl_frame_t xlat_fill_frame,
	input wire logic invalidate_page_translation,
	input wire mcl_page_t inv_page,
	input wire logic page_table_base_register_wr,
	input wire logic xlat_lookup,
	input wire mcl_page_t xlat_page,
	output logic xlat_hit,
	output mcl_frame_t xlat_frame
);

	// Effect of an incoming probe on one line
	function automatic mcl_line_t probe_next(input mcl_line_t s,
		input logic wr, input logic caching);
		mcl_line_t r;
		r = s;
		if (wr) begin
			r = line_inv;
		end else if (caching) begin
			if (s == line_mod)
				r = line_own;
			else if (s == line_exc)
				r = line_shr;
		end
		return r;
	endfunction

	// Dirty holders are the ones that must supply data
	function automatic logic is_dirty(input mcl_line_t s);
		return (s == line_mod) || (s == line_own);
	endfunction

	mcl_line_t lines [`MCL_LINES];
	mcl_line_t next_lines [`MCL_LINES];
	mcl_fsm_t fsm, next_fsm;
	logic op_write, next_op_write;
	logic op_upg, next_op_upg;
	logic op_shared, next_op_shared;
	mcl_idx_t op_idx, next_op_idx;
	logic next_lcl_ready, next_lcl_done;
	mcl_line_t next_lcl_state;
	logic next_prb_req, next_prb_write, next_mem_rd;
	mcl_idx_t next_prb_idx;
	logic next_snp_hit, next_snp_supply;
	logic take;
	mcl_line_t cur;

	assign take = lcl_req && lcl_ready && (fsm == fsm_idle);
	assign cur = lines[lcl_idx];

	// Local sequencing; probe effect applied on top of local result
	always_comb begin
		next_lines = lines;
		next_fsm = fsm;
		next_op_write = op_write;
		next_op_upg = op_upg;
		next_op_shared = op_shared;
		next_op_idx = op_idx;
		next_lcl_done = 1'b0;
		next_lcl_state = lcl_state;
		next_prb_req = 1'b0;
		next_prb_write = prb_write;
		next_prb_idx = prb_idx;
		next_mem_rd = 1'b0;
		unique case (fsm)
			fsm_idle: begin
				if (take) begin
					next_op_idx = lcl_idx;
					next_op_write = lcl_write;
					if (cur != line_inv && !lcl_write) begin
						// Read hit: state untouched
						next_lcl_done = 1'b1;
						next_lcl_state = cur;
					end else if (cur == line_mod || cur == line_exc) begin
						next_lines[lcl_idx] = line_mod;
						next_lcl_done = 1'b1;
						next_lcl_state = line_mod;
					end else begin
						// Miss, or write to a copy others may hold
						next_op_upg = (cur != line_inv);
						next_prb_req = 1'b1;
						next_prb_write = lcl_write;
						next_prb_idx = lcl_idx;
						next_fsm = fsm_probe;
					end
				end
			end
			fsm_probe: begin
				next_prb_req = !prb_ack;
				if (prb_ack) begin
					next_op_shared = prb_shared;
					// Memory only answers a miss when no cache supplied the data
					next_mem_rd = !prb_cache_data && !op_upg;
					next_fsm = op_upg ? fsm_upgrade : fsm_fill;
				end
			end
			fsm_fill: begin
				// Sharers seen on a read fill: shared, else exclusive
				if (!op_write && op_shared)
					next_lines[op_idx] = line_shr;
				else
					next_lines[op_idx] = line_exc;
				next_lcl_done = !op_write;
				next_lcl_state = (!op_write && op_shared) ?
					line_shr : line_exc;
				next_fsm = op_write ? fsm_upgrade : fsm_idle;
			end
			fsm_upgrade: begin
				// Others were invalidated by the write probe
				next_lines[op_idx] = line_mod;
				next_lcl_done = 1'b1;
				next_lcl_state = line_mod;
				next_op_upg = 1'b0;
				next_fsm = fsm_idle;
			end
		endcase
		// Incoming probe lands last, so the same cycle's local update never overrides it
		if (snp_valid)
			next_lines[snp_idx] = probe_next(next_lines[snp_idx],
				snp_write, snp_caching);
		next_snp_hit = snp_valid && (lines[snp_idx] != line_inv);
		// Owner or modified holder provides data
		next_snp_supply = snp_valid && is_dirty(lines[snp_idx]);
		next_lcl_ready = (next_fsm == fsm_idle);
	end

	// Line state and sequencer registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < `MCL_LINES; i++)
				lines[i] <= line_inv;
			fsm <= fsm_idle;
			op_write <= 1'b0;
			op_upg <= 1'b0;
			op_shared <= 1'b0;
			op_idx <= '0;
			lcl_ready <= 1'b1;
			lcl_done <= 1'b0;
			lcl_state <= line_inv;
			prb_req <= 1'b0;
			prb_write <= 1'b0;
			prb_idx <= '0;
			mem_rd <= 1'b0;
			snp_hit <= 1'b0;
			snp_supply <= 1'b0;
		end else if (ce) begin
			lines <= next_lines;
			fsm <= next_fsm;
			op_write <= next_op_write;
			op_upg <= next_op_upg;
			op_shared <= next_op_shared;
			op_idx <= next_op_idx;
			lcl_ready <= next_lcl_ready;
			lcl_done <= next_lcl_done;
			lcl_state <= next_lcl_state;
			prb_req <= next_prb_req;
			prb_write <= next_prb_write;
			prb_idx <= next_prb_idx;
			mem_rd <= next_mem_rd;
			snp_hit <= next_snp_hit;
			snp_supply <= next_snp_supply;
		end
	end

	// Translation store; a lookup may read an entry until it is dropped
	logic xv [`MCL_PAGES];
	logic next_xv [`MCL_PAGES];
	mcl_frame_t xf [`MCL_PAGES];
	mcl_frame_t next_xf [`MCL_PAGES];
	logic next_xlat_hit;
	mcl_frame_t next_xlat_frame;

	generate
		for (genvar g = 0; g < `MCL_PAGES; g++) begin : g_xlat
			// Invalidate beats a fill to the same page, stale is worse
			always_comb begin
				next_xv[g] = xv[g];
				next_xf[g] = xf[g];
				if (xlat_fill && xlat_fill_page == mcl_page_t'(g)) begin
					next_xv[g] = 1'b1;
					next_xf[g] = xlat_fill_frame;
				end
				if (page_table_base_register_wr ||
					(invalidate_page_translation &&
					inv_page == mcl_page_t'(g)))
					next_xv[g] = 1'b0;
			end
		end
	endgenerate

	// Lookup answers from the state before this cycle's updates
	always_comb begin
		next_xlat_hit = xlat_lookup && xv[xlat_page];
		next_xlat_frame = xlat_lookup ? xf[xlat_page] : xlat_frame;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < `MCL_PAGES; i++) begin
				xv[i] <= 1'b0;
				xf[i] <= `MCL_FRAME_RST;
			end
			xlat_hit <= 1'b0;
			xlat_frame <= `MCL_FRAME_RST;
		end else if (ce) begin
			xv <= next_xv;
			xf <= next_xf;
			xlat_hit <= next_xlat_hit;
			xlat_frame <= next_xlat_frame;
		end
	end

	// Checks
	logic quiet;
	assign quiet = !(snp_valid && snp_idx == lcl_idx);

	property p_read_hit;
		@(posedge ref_clk) disable iff (rst)
		ce && take && !lcl_write && cur != line_inv && quiet
			|=> lines[$past(lcl_idx)] == $past(cur) && lcl_done;
	endproperty
	a_read_hit: assert property (p_read_hit)
		else $error("read hit changed line state");

	property p_write_hit;
		@(posedge ref_clk) disable iff (rst)
		ce && take && lcl_write && (cur == line_exc || cur == line_mod)
			&& quiet |=> lines[$past(lcl_idx)] == line_mod;
	endproperty
	a_write_hit: assert property (p_write_hit)
		else $error("write hit did not give modified");

	property p_wprobe;
		@(posedge ref_clk) disable iff (rst)
		ce && snp_valid && snp_write
			|=> lines[$past(snp_idx)] == line_inv;
	endproperty
	a_wprobe: assert property (p_wprobe)
		else $error("write probe left line valid");

	property p_supply;
		@(posedge ref_clk) disable iff (rst)
		ce && snp_valid |=> snp_supply == is_dirty($past(lines[snp_idx]));
	endproperty
	a_supply: assert property (p_supply)
		else $error("probe supply wrong for line state");

	property p_rprobe_mod;
		@(posedge ref_clk) disable iff (rst)
		ce && snp_valid && !snp_write && snp_caching &&
			lines[snp_idx] == line_mod && !(fsm != fsm_idle &&
			op_idx == snp_idx) && !(take && !quiet)
			|=> lines[$past(snp_idx)] == line_own;
	endproperty
	a_rprobe_mod: assert property (p_rprobe_mod)
		else $error("caching read probe did not give owned");

	property p_rprobe_io;
		@(posedge ref_clk) disable iff (rst)
		ce && snp_valid && !snp_write && !snp_caching && fsm == fsm_idle
			&& !take |=> lines[$past(snp_idx)] == $past(lines[snp_idx]);
	endproperty
	a_rprobe_io: assert property (p_rprobe_io)
		else $error("non-caching probe changed line state");

	property p_miss_probe;
		@(posedge ref_clk) disable iff (rst)
		ce && take && cur == line_inv
			|=> prb_req && prb_write == $past(lcl_write) && !lcl_ready;
	endproperty
	a_miss_probe: assert property (p_miss_probe)
		else $error("miss did not issue a probe");

	property p_mem_rd;
		@(posedge ref_clk) disable iff (rst)
		ce && fsm == fsm_probe && prb_ack && !op_upg && !prb_cache_data
			|=> mem_rd ##1 (!ce || !mem_rd);
	endproperty
	a_mem_rd: assert property (p_mem_rd)
		else $error("memory not read when no cache supplied");

	property p_inv_page;
		@(posedge ref_clk) disable iff (rst)
		ce && invalidate_page_translation ##1 ce && xlat_lookup &&
			xlat_page == $past(inv_page) && !xlat_fill
			|=> !xlat_hit;
	endproperty
	a_inv_page: assert property (p_inv_page)
		else $error("translation survived page invalidate");

	property p_base_wr;
		@(posedge ref_clk) disable iff (rst)
		ce && page_table_base_register_wr |=> !xv[0] && !xv[7];
	endproperty
	a_base_wr: assert property (p_base_wr)
		else $error("translations survived base register write");

	property p_wmiss_seq;
		@(posedge ref_clk) disable iff (rst)
		ce && fsm == fsm_fill && op_write
			|=> fsm == fsm_upgrade && lines[op_idx] != line_mod;
	endproperty
	a_wmiss_seq: assert property (p_wmiss_seq)
		else $error("write miss skipped exclusive step");

	c_read_miss: cover property (@(posedge ref_clk) disable iff (rst)
		fsm == fsm_fill && !op_write ##1 lcl_done);
	c_write_miss: cover property (@(posedge ref_clk) disable iff (rst)
		fsm == fsm_upgrade && !op_upg ##1 lcl_state == line_mod);
	c_upgrade: cover property (@(posedge ref_clk) disable iff (rst)
		fsm == fsm_upgrade && op_upg);
	c_owned: cover property (@(posedge ref_clk) disable iff (rst)
		snp_supply && snp_hit);

endmodule

// >>> test/mcl_bus_peer.sv
// Far-side caches and memory as seen by the outgoing probe handshake
module mcl_bus_peer (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Probe handshake and memory fetch
	input wire logic prb_req,
	output logic prb_ack,
	output logic prb_shared,
	output logic prb_cache_data,
	input wire logic mem_rd,
	// Answer shaping from the bench
	input wire logic slow,
	input wire logic want_shared,
	input wire logic want_data,
	output logic [15:0] mem_count
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [2:0] cnt;
	logic pat;

	// Answer flags are junk outside the ack cycle, never a stale value
	assign prb_shared = prb_ack ? want_shared : pat;
	assign prb_cache_data = prb_ack ? want_data : ~pat;

	// One ack per probe, prompt or after a few idle cycles
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt <= 3'h0;
			prb_ack <= 1'b0;
			pat <= 1'b0;
			mem_count <= 16'h0000;
		end else begin
			pat <= ~pat;
			prb_ack <= 1'b0;
			if (mem_rd)
				mem_count <= mem_count + 16'h0001;
			if (prb_req && !prb_ack) begin
				if (cnt == (slow ? 3'h5 : 3'h0)) begin
					prb_ack <= 1'b1;
					cnt <= 3'h0;
				end else
					cnt <= cnt + 3'h1;
			end
		end
	end
endmodule

// >>> test/testbench.sv
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
	$display("ERROR %0t: got %h want %h", $time, a, b); end end

module testbench
	import mcl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic ref_clk, rst, ce, lcl_req, lcl_write, lcl_ready, lcl_done;
	logic prb_req, prb_write, prb_ack, prb_shared, prb_cache_data, mem_rd;
	logic snp_valid, snp_write, snp_caching, snp_hit, snp_supply;
	logic xlat_fill, invalidate_page_translation;
	logic page_table_base_register_wr, xlat_lookup, xlat_hit;
	logic slow, want_shared, want_data;
	logic [15:0] mem_count;
	mcl_idx_t lcl_idx, prb_idx, snp_idx;
	mcl_page_t xlat_fill_page, inv_page, xlat_page;
	mcl_frame_t xlat_fill_frame, xlat_frame;
	mcl_line_t lcl_state;
	mcl_line_t m[8];
	logic tv[8];
	mcl_frame_t tf[8];
	int seed = 14562;
	int miscompares = 0;
	int checked = 0;
	int mem_exp = 0;
	logic [31:0] r;

	mcl_line_state dut (.*);
	mcl_bus_peer peer (.*);

	function automatic mcl_line_t after_local(mcl_line_t s, logic w,
		logic sh);
		if (w)
			return line_mod;
		if (s != line_inv)
			return s;
		return sh ? line_shr : line_exc;
	endfunction

	function automatic mcl_line_t after_snoop(mcl_line_t s, logic w,
		logic c);
		if (w)
			return line_inv;
		if (c && s == line_mod)
			return line_own;
		if (c && s == line_exc)
			return line_shr;
		return s;
	endfunction

	// One local access, waits for completion under a bound
	task automatic lop(logic w, mcl_idx_t i);
		mcl_line_t e;
		logic miss;
		e = after_local(m[i], w, want_shared);
		miss = m[i] == line_inv || (w && (m[i] == line_shr
			|| m[i] == line_own));
		if (m[i] == line_inv && !want_data)
			mem_exp++;
		@(posedge ref_clk);
		lcl_req <= 1'b1;
		lcl_write <= w;
		lcl_idx <= i;
		@(posedge ref_clk);
		lcl_req <= 1'b0;
		#1;
		if (miss) begin
			`CHK(prb_req, 1'b1)
			`CHK(prb_write, w)
			`CHK(prb_idx, i)
			`CHK(lcl_ready, 1'b0)
		end
		for (int k = 0; k < 40 && lcl_done !== 1'b1; k++) begin
			@(posedge ref_clk);
			#1;
		end
		`CHK(lcl_done, 1'b1)
		`CHK(lcl_state, e)
		m[i] = e;
	endtask

	// Incoming probe, answer one cycle later
	task automatic sop(logic w, logic c, mcl_idx_t i);
		@(posedge ref_clk);
		snp_valid <= 1'b1;
		snp_write <= w;
		snp_caching <= c;
		snp_idx <= i;
		@(posedge ref_clk);
		snp_valid <= 1'b0;
		#1;
		`CHK(snp_hit, m[i] != line_inv)
		`CHK(snp_supply, m[i] == line_mod || m[i] == line_own)
		m[i] = after_snoop(m[i], w, c);
	endtask

	// Translation fill, drop, flush and lookup in one cycle
	task automatic xop(logic fl, logic iv, logic bw, logic lk,
		mcl_page_t p, mcl_page_t q, mcl_frame_t f);
		logic eh;
		mcl_frame_t ef;
		eh = tv[q];
		ef = tf[q];
		@(posedge ref_clk);
		xlat_fill <= fl;
		xlat_fill_page <= p;
		xlat_fill_frame <= f;
		invalidate_page_translation <= iv;
		inv_page <= q;
		page_table_base_register_wr <= bw;
		xlat_lookup <= lk;
		xlat_page <= q;
		@(posedge ref_clk);
		{xlat_fill, invalidate_page_translation} <= 2'h0;
		{page_table_base_register_wr, xlat_lookup} <= 2'h0;
		#1;
		`CHK(xlat_hit, lk & eh)
		if (lk && eh)
			`CHK(xlat_frame, ef)
		if (fl)
			{tv[p], tf[p]} = {1'b1, f};
		if (iv)
			tv[q] = 1'b0;
		if (bw)
			tv = '{default: 1'b0};
	endtask

	task automatic close_out;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Free-running clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Hang guard, well past the expected run length
	initial begin
		#500000;
		miscompares++;
		close_out;
	end

	initial begin
		{rst, ce, slow, want_shared, want_data} = 5'h18;
		{lcl_req, lcl_write, snp_valid, snp_write, snp_caching} = 5'h00;
		{xlat_fill, invalidate_page_translation} = 2'h0;
		{page_table_base_register_wr, xlat_lookup} = 2'h0;
		{lcl_idx, snp_idx, xlat_fill_page, inv_page, xlat_page} = 15'h0000;
		xlat_fill_frame = 8'h00;
		m = '{default: line_inv};
		tv = '{default: 1'b0};
		tf = '{default: 8'h00};
		repeat (10) @(posedge ref_clk);
		`CHK(lcl_ready, 1'b1)
		`CHK({prb_req, lcl_done, snp_hit, xlat_hit}, 4'h0)
		rst <= 1'b0;
		// Owner path: mod, owned on caching read, upgrade, flush by write
		lop(1'b1, 3'h0);
		sop(1'b0, 1'b1, 3'h0);
		lop(1'b0, 3'h0);
		lop(1'b1, 3'h0);
		sop(1'b0, 1'b0, 3'h0);
		lop(1'b0, 3'h0);
		lop(1'b1, 3'h0);
		sop(1'b1, 1'b0, 3'h0);
		lop(1'b0, 3'h0);
		// Exclusive demoted to shared, then upgraded
		lop(1'b0, 3'h1);
		sop(1'b0, 1'b1, 3'h1);
		lop(1'b0, 3'h1);
		lop(1'b1, 3'h1);
		// Same-cycle drop beats fill, flush beats fill
		xop(1'b1, 1'b0, 1'b0, 1'b0, 3'h2, 3'h0, 8'h5A);
		xop(1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 3'h2, 8'h00);
		xop(1'b1, 1'b1, 1'b0, 1'b0, 3'h3, 3'h3, 8'hC3);
		xop(1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 3'h3, 8'h00);
		xop(1'b1, 1'b0, 1'b1, 1'b0, 3'h4, 3'h0, 8'h11);
		xop(1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 3'h4, 8'h00);
		// Random mix of all three groups
		for (int n = 0; n < 300; n++) begin
			r = $random(seed);
			slow <= r[13];
			want_shared <= r[11];
			want_data <= r[12];
			@(posedge ref_clk);
			case (r[1:0])
				2'h0, 2'h1:
					lop(r[7], r[6:4]);
				2'h2:
					sop(r[7], r[8], r[6:4]);
				default:
					xop(r[14], r[15], r[16] & r[17] & r[18], r[19],
						r[6:4], r[22:20], r[31:24]);
			endcase
		end
		`CHK(mem_count, mem_exp[15:0])
		close_out;
	end
endmodule
